// File: src/xpc_pkg.sv
package xpc_pkg;
  // Lane layout
  localparam int LANES  = 8;
  localparam int LANE_W = 9;
  localparam int BUS_W  = 72;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 9;
  localparam int AXI_AW = 11;

  // Local register word indices
  localparam logic [8:0]  REG_CTRL   = 9'h1f0;
  localparam logic [8:0]  REG_STAT   = 9'h1f1;
  localparam logic [8:0]  REG_TXCNT  = 9'h1f2;
  localparam logic [8:0]  REG_RXDROP = 9'h1f3;
  localparam logic [4:0]  LOCAL_PAGE = 5'h1f;
  localparam logic [8:0]  PMA_TOP    = 9'h07f;

  // Field positions and reset values
  localparam int          CTRL_TXEN    = 0;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam int          ST_LOCK      = 0;
  localparam int          ST_HIBER     = 1;
  localparam int          ST_RSTBUSY   = 2;
  localparam int          ST_TXCLK_LSB = 8;

  // Timing
  localparam int  SYS_MHZ      = 250;
  localparam real LANE_CLK_MHZ = 156.25;
  localparam int  RXCLK_HALF   = 1;
  localparam int  RST_HOLD_NS  = 100;
  localparam int  RST_HOLD_CYC = (RST_HOLD_NS * SYS_MHZ + 999) / 1000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_WR_FWD = 3'h2,
    ST_RD_FWD = 3'h4
  } xpc_state_t;
endpackage : xpc_pkg

// File: src/xpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module xpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : xpc_sync
`default_nettype wire

// File: src/xpc_host_ports.sv
// Functional notes
// - TX bus is 72 bits, eight 9-bit lanes
// - Unpack TX lanes into 64 data, 8 control
// - Pack RX data and control into lanes
// - Raise TX ready when channel accepts data
// - MAC ready gates RX valid, latency zero
// - PCS sources RX bus toward the MAC
// - Device outputs RX lane clock
// - Management reset rising edge resets PHY
// - Nine-bit word address, 32-bit data buses
// - Stall holds pending request unchanged
// - Bridge forwards commands to inner slaves
// - Status option brings out lock, error flags
// - External PMA option removes PMA region
// - Block lock follows block synchroniser
// - High error flag follows error monitor
`timescale 1ns/100ps
`default_nettype none
module xpc_host_ports #(
  parameter logic       ADD_STATUS_PINS = 1'b1,
  parameter logic       EXT_PMA_CTRL    = 1'b0,
  parameter logic [6:0] START_CHANNEL   = 7'h00
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic        TX_LANE_CLK,
  input  wire logic [71:0] TX_LANE_BUS,
  input  wire logic        TX_LANE_VALID,
  output logic             TX_READY,
  output logic      [63:0] PCS_TX_DATA,
  output logic      [7:0]  PCS_TX_CTRL,
  output logic             PCS_TX_VALID,
  input  wire logic [63:0] PCS_RX_DATA,
  input  wire logic [7:0]  PCS_RX_CTRL,
  input  wire logic        PCS_RX_VALID,
  output logic      [71:0] RX_LANE_BUS,
  output logic             RX_LANE_VALID,
  input  wire logic        RX_LANE_READY,
  output logic             RX_LANE_CLK,
  input  wire logic        MGMT_RESET,
  output logic             PHY_RESET,
  input  wire logic        BLOCK_LOCK_IN,
  input  wire logic        HIGH_ERROR_RATE_IN,
  output logic             BLOCK_LOCK,
  output logic             HIGH_ERROR_RATE_FLAG,
  input  wire logic [10:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [10:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic      [8:0]  BR_ADDR,
  output logic      [31:0] BR_WDATA,
  output logic             BR_WRITE,
  output logic             BR_READ,
  input  wire logic [31:0] BR_RDATA,
  input  wire logic        BR_WAIT
);

  // Split a lane bus into {control, data}
  function automatic logic [71:0] unpack_lanes(input logic [71:0] bus);
    logic [71:0] r;
    r = '0;
    for (int k = 0; k < xpc_pkg::LANES; k++) begin
      r[8*k +: 8] = bus[9*k +: 8];
      r[64 + k]   = bus[9*k + 8];
    end
    return r;
  endfunction : unpack_lanes

  // Interleave data and control into nine-bit lanes
  function automatic logic [71:0] pack_lanes(input logic [63:0] d,
                                             input logic [7:0]  c);
    logic [71:0] r;
    r = '0;
    for (int k = 0; k < xpc_pkg::LANES; k++) begin
      r[9*k +: 8] = d[8*k +: 8];
      r[9*k + 8]  = c[k];
    end
    return r;
  endfunction : pack_lanes

  // Word index lies on the local page
  function automatic logic is_local(input logic [8:0] idx);
    return idx[8:4] == xpc_pkg::LOCAL_PAGE;
  endfunction : is_local

  // Word index names an implemented local register
  function automatic logic reg_known(input logic [8:0] idx);
    return is_local(idx) && idx[3:2] == 2'h0;
  endfunction : reg_known

  // Index may be forwarded over the bridge
  function automatic logic fwd_ok(input logic [8:0] idx);
    return !is_local(idx) && !(EXT_PMA_CTRL && idx <= xpc_pkg::PMA_TOP);
  endfunction : fwd_ok

  logic [3:0] sync_q;
  logic       mrst_d_r;
  logic       txclk_d_r;
  logic [7:0] rst_cnt_r;
  logic [7:0] rst_cnt_nxt;
  logic       tx_ready_r;
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] tx_cnt_r;
  logic [31:0] rx_drop_r;
  logic [7:0] txclk_cnt_r;
  logic       rx_valid_r;
  logic       rxclk_r;
  logic [3:0] rxdiv_r;
  logic       aw_have_r;
  logic       w_have_r;
  logic       ar_have_r;
  logic [8:0] aw_idx_r;
  logic [8:0] ar_idx_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       awready_r;
  logic       wready_r;
  logic       arready_r;
  logic       bvalid_r;
  logic       rvalid_r;
  xpc_pkg::xpc_state_t state_r;
  xpc_pkg::xpc_state_t state_nxt;

  // Pin inputs through two flip-flops
  xpc_sync #(.W(4)) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .d     ({HIGH_ERROR_RATE_IN, BLOCK_LOCK_IN, MGMT_RESET, TX_LANE_CLK}),
    .q     (sync_q)
  );

  wire txclk_s = sync_q[0];
  wire mrst_s  = sync_q[1];
  wire lock_s  = sync_q[2];
  wire hiber_s = sync_q[3];

  // Management reset edge starts a fixed reset pulse
  wire mrst_rise = mrst_s & ~mrst_d_r;
  assign rst_cnt_nxt = mrst_rise ? 8'(xpc_pkg::RST_HOLD_CYC) :
                       (rst_cnt_r != 8'h00) ? rst_cnt_r - 8'h01 : 8'h00;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mrst_d_r  <= 1'b0;
      rst_cnt_r <= 8'(xpc_pkg::RST_HOLD_CYC);
      PHY_RESET <= 1'b1;
    end else begin
      mrst_d_r  <= mrst_s;
      rst_cnt_r <= rst_cnt_nxt;
      PHY_RESET <= rst_cnt_nxt != 8'h00;
    end
  end

  // TX sink: accept only while ready, then unpack lanes
  wire        tx_take = TX_LANE_VALID & tx_ready_r;
  wire [71:0] tx_unp  = unpack_lanes(TX_LANE_BUS);
  assign TX_READY = tx_ready_r;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      tx_ready_r   <= 1'b0;
      PCS_TX_VALID <= 1'b0;
      PCS_TX_DATA  <= '0;
      PCS_TX_CTRL  <= '0;
      tx_cnt_r     <= '0;
    end else begin
      tx_ready_r   <= ctrl_r[xpc_pkg::CTRL_TXEN] &
                      (rst_cnt_nxt == 8'h00);
      PCS_TX_VALID <= tx_take;
      tx_cnt_r     <= tx_cnt_r + 32'(tx_take);
      if (tx_take) begin
        PCS_TX_DATA <= tx_unp[63:0];
        PCS_TX_CTRL <= tx_unp[71:64];
      end
    end
  end

  // TX lane clock activity counter
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      txclk_d_r   <= 1'b0;
      txclk_cnt_r <= '0;
    end else begin
      txclk_d_r   <= txclk_s;
      txclk_cnt_r <= txclk_cnt_r + 8'(txclk_s & ~txclk_d_r);
    end
  end

  // RX source: output register holds while MAC stalls
  wire rx_room = ~rx_valid_r | RX_LANE_READY;
  wire rx_load = PCS_RX_VALID & rx_room;
  wire rx_drop = PCS_RX_VALID & ~rx_room;
  assign RX_LANE_VALID = rx_valid_r;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rx_valid_r  <= 1'b0;
      RX_LANE_BUS <= '0;
      rx_drop_r   <= '0;
    end else begin
      rx_valid_r <= rx_load | (rx_valid_r & ~RX_LANE_READY);
      rx_drop_r  <= rx_drop_r + 32'(rx_drop);
      if (rx_load) begin
        RX_LANE_BUS <= pack_lanes(PCS_RX_DATA, PCS_RX_CTRL);
      end
    end
  end

  // RX lane clock divided from the system clock
  assign RX_LANE_CLK = rxclk_r;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rxclk_r <= 1'b0;
      rxdiv_r <= '0;
    end else if (rxdiv_r == 4'(xpc_pkg::RXCLK_HALF - 1)) begin
      rxclk_r <= ~rxclk_r;
      rxdiv_r <= '0;
    end else begin
      rxdiv_r <= rxdiv_r + 4'h1;
    end
  end

  // Optional status pins
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      BLOCK_LOCK           <= 1'b0;
      HIGH_ERROR_RATE_FLAG <= 1'b0;
    end else begin
      BLOCK_LOCK           <= ADD_STATUS_PINS & lock_s;
      HIGH_ERROR_RATE_FLAG <= ADD_STATUS_PINS & hiber_s;
    end
  end

  // Register bus decode
  wire aw_take  = S_AXI_AWVALID & awready_r;
  wire w_take   = S_AXI_WVALID & wready_r;
  wire ar_take  = S_AXI_ARVALID & arready_r;
  wire idle     = state_r == xpc_pkg::ST_IDLE;
  wire wr_fire  = idle & aw_have_r & w_have_r & ~bvalid_r;
  wire rd_fire  = idle & ar_have_r & ~rvalid_r & ~wr_fire;
  wire wr_fwd   = wr_fire & fwd_ok(aw_idx_r);
  wire rd_fwd   = rd_fire & fwd_ok(ar_idx_r);
  wire wr_fend  = (state_r == xpc_pkg::ST_WR_FWD) & ~BR_WAIT;
  wire rd_fend  = (state_r == xpc_pkg::ST_RD_FWD) & ~BR_WAIT;
  wire wr_done  = (wr_fire & ~wr_fwd) | wr_fend;
  wire rd_done  = (rd_fire & ~rd_fwd) | rd_fend;
  wire ctrl_wr  = wr_fire & (aw_idx_r == xpc_pkg::REG_CTRL);
  wire [1:0] wr_resp = (wr_fend | reg_known(aw_idx_r)) ?
                       xpc_pkg::RESP_OKAY : xpc_pkg::RESP_SLVERR;
  wire [1:0] rd_resp = (rd_fend | reg_known(ar_idx_r)) ?
                       xpc_pkg::RESP_OKAY : xpc_pkg::RESP_SLVERR;
  wire [31:0] stat_word = {16'h0000, txclk_cnt_r, 5'h00,
                           rst_cnt_r != 8'h00, hiber_s, lock_s};
  wire [31:0] rd_local =
    (ar_idx_r == xpc_pkg::REG_CTRL)   ? ctrl_r    :
    (ar_idx_r == xpc_pkg::REG_STAT)   ? stat_word :
    (ar_idx_r == xpc_pkg::REG_TXCNT)  ? tx_cnt_r  :
    (ar_idx_r == xpc_pkg::REG_RXDROP) ? rx_drop_r : 32'h0000_0000;

  // Byte-lane merge for the control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    for (int b = 0; b < 4; b++) begin
      if (ctrl_wr && w_strb_r[b]) begin
        ctrl_nxt[8*b +: 8] = w_data_r[8*b +: 8];
      end
    end
  end

  // Bridge sequencer
  always_comb begin
    case (state_r)
      xpc_pkg::ST_IDLE:   state_nxt = wr_fwd ? xpc_pkg::ST_WR_FWD :
                                      rd_fwd ? xpc_pkg::ST_RD_FWD :
                                      xpc_pkg::ST_IDLE;
      xpc_pkg::ST_WR_FWD: state_nxt = BR_WAIT ? xpc_pkg::ST_WR_FWD :
                                      xpc_pkg::ST_IDLE;
      xpc_pkg::ST_RD_FWD: state_nxt = BR_WAIT ? xpc_pkg::ST_RD_FWD :
                                      xpc_pkg::ST_IDLE;
      default:            state_nxt = xpc_pkg::ST_IDLE;
    endcase
  end

  // Address and data capture; ready low is the stall
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      ar_have_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
      aw_idx_r  <= '0;
      ar_idx_r  <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      aw_have_r <= aw_take | (aw_have_r & ~wr_done);
      w_have_r  <= w_take | (w_have_r & ~wr_done);
      ar_have_r <= ar_take | (ar_have_r & ~rd_done);
      awready_r <= ~(aw_take | (aw_have_r & ~wr_done));
      wready_r  <= ~(w_take | (w_have_r & ~wr_done));
      arready_r <= ~(ar_take | (ar_have_r & ~rd_done));
      if (aw_take) aw_idx_r <= S_AXI_AWADDR[10:2];
      if (ar_take) ar_idx_r <= S_AXI_ARADDR[10:2];
      if (w_take) begin
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY  = wready_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_RVALID  = rvalid_r;

  // Forwarding, local registers and responses
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_r     <= xpc_pkg::ST_IDLE;
      ctrl_r      <= xpc_pkg::CTRL_RST;
      BR_ADDR     <= '0;
      BR_WDATA    <= '0;
      BR_WRITE    <= 1'b0;
      BR_READ     <= 1'b0;
      bvalid_r    <= 1'b0;
      rvalid_r    <= 1'b0;
      S_AXI_BRESP <= xpc_pkg::RESP_OKAY;
      S_AXI_RRESP <= xpc_pkg::RESP_OKAY;
      S_AXI_RDATA <= '0;
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
      if (wr_fwd) begin
        BR_ADDR  <= aw_idx_r;
        BR_WDATA <= w_data_r;
      end else if (rd_fwd) begin
        BR_ADDR  <= ar_idx_r;
      end
      BR_WRITE <= wr_fwd | (BR_WRITE & BR_WAIT);
      BR_READ  <= rd_fwd | (BR_READ & BR_WAIT);
      if (wr_done) begin
        bvalid_r    <= 1'b1;
        S_AXI_BRESP <= wr_resp;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
      if (rd_done) begin
        rvalid_r    <= 1'b1;
        S_AXI_RRESP <= rd_resp;
        S_AXI_RDATA <= rd_fend ? BR_RDATA : rd_local;
      end else if (S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Checks
  localparam int RST_CHK_MAX = xpc_pkg::RST_HOLD_CYC + 2;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  chk_tx_unpack: assert property (
    tx_take |=> PCS_TX_VALID &&
      PCS_TX_DATA[7:0] == $past(TX_LANE_BUS[7:0]) &&
      PCS_TX_DATA[63:56] == $past(TX_LANE_BUS[70:63]) &&
      PCS_TX_CTRL[7] == $past(TX_LANE_BUS[71]))
    else $error("TX lanes unpacked wrongly");
  chk_tx_ignore: assert property (
    !TX_READY |=> !PCS_TX_VALID)
    else $error("TX word taken while not ready");
  chk_tx_ready: assert property (
    PHY_RESET |-> !TX_READY)
    else $error("TX ready during PHY reset");
  chk_rx_pack: assert property (
    rx_load |=> RX_LANE_VALID &&
      RX_LANE_BUS[70:63] == $past(PCS_RX_DATA[63:56]) &&
      RX_LANE_BUS[8] == $past(PCS_RX_CTRL[0]))
    else $error("RX lanes packed wrongly");
  chk_rx_hold: assert property (
    RX_LANE_VALID && !RX_LANE_READY |=>
      RX_LANE_VALID && $stable(RX_LANE_BUS))
    else $error("RX word changed under stall");
  chk_reset_pulse: assert property (
    mrst_rise |=> PHY_RESET[*8] ##[1:RST_CHK_MAX] !PHY_RESET)
    else $error("PHY reset pulse wrong length");
  chk_bridge_hold: assert property (
    (BR_WRITE || BR_READ) && BR_WAIT |=>
      $stable(BR_ADDR) && $stable(BR_WDATA) &&
      $stable(BR_WRITE) && $stable(BR_READ))
    else $error("Bridge request changed while stalled");
  chk_bridge_read: assert property (
    BR_READ && !BR_WAIT |=>
      S_AXI_RVALID && S_AXI_RDATA == $past(BR_RDATA) && !BR_READ)
    else $error("Forwarded read data lost");
  chk_status_pins: assert property (
    ##1 BLOCK_LOCK == (ADD_STATUS_PINS && $past(lock_s)) &&
      HIGH_ERROR_RATE_FLAG == (ADD_STATUS_PINS && $past(hiber_s)))
    else $error("Status pin does not follow flag");
  chk_ext_pma: assert property (
    BR_WRITE || BR_READ |-> !(EXT_PMA_CTRL && BR_ADDR <= xpc_pkg::PMA_TOP))
    else $error("PMA region forwarded while external");

  cov_tx_take:  cover property (tx_take ##1 tx_take);
  cov_rx_stall: cover property (RX_LANE_VALID && !RX_LANE_READY ##1
                                RX_LANE_READY);
  cov_br_wait:  cover property (BR_READ && BR_WAIT ##1 !BR_WAIT);
  cov_mrst:     cover property (mrst_rise);
endmodule : xpc_host_ports
`default_nettype wire

// File: tb/xpc_bridge_model.sv
`timescale 1ns/100ps
`default_nettype none
module xpc_bridge_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [8:0]  br_addr,
  input  wire logic [31:0] br_wdata,
  input  wire logic        br_write,
  input  wire logic        br_read,
  output logic      [31:0] br_rdata,
  output logic             br_wait
);
  logic [31:0] mem [512];
  logic [31:0] noise_r;
  logic [1:0]  cnt_r;
  logic        strobe;

  // Stall while wait states remain, then take the command
  assign strobe   = br_write | br_read;
  assign br_wait  = strobe & (cnt_r != 2'h0);
  // Read word only in the taking cycle, a moving pattern elsewhere
  assign br_rdata = (br_read & !br_wait) ? mem[br_addr] : noise_r;

  initial begin
    cnt_r   = 2'h0;
    noise_r = 32'h0;
  end

  // Reload wait states between commands and store taken writes
  always @(posedge clk) begin
    noise_r <= noise_r + 32'h9e37_79b9;
    if (!strobe)
      cnt_r <= slow ? 2'($urandom_range(3, 1)) : 2'h0;
    else if (br_wait)
      cnt_r <= cnt_r - 2'h1;
    if (br_write & !br_wait)
      mem[br_addr] <= br_wdata;
  end
endmodule : xpc_bridge_model
`default_nettype wire

// File: tb/xpc_host_ports_test.sv
`timescale 1ns/100ps
`default_nettype none
module xpc_host_ports_test;
  logic        CLK_SYS, RESETN, TX_LANE_CLK, TX_LANE_VALID, TX_READY;
  logic        PCS_TX_VALID, PCS_RX_VALID, RX_LANE_VALID, RX_LANE_READY;
  logic        RX_LANE_CLK, MGMT_RESET, PHY_RESET, BLOCK_LOCK_IN, BLOCK_LOCK;
  logic        HIGH_ERROR_RATE_IN, HIGH_ERROR_RATE_FLAG, slow;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY, BR_WRITE, BR_READ, BR_WAIT;
  logic [71:0] TX_LANE_BUS, RX_LANE_BUS;
  logic [63:0] PCS_TX_DATA, PCS_RX_DATA;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, BR_WDATA, BR_RDATA;
  logic [10:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [8:0]  BR_ADDR;
  logic [7:0]  PCS_TX_CTRL, PCS_RX_CTRL;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  int          failures, cmp_count, rx_drops, tx_taken;
  logic [71:0] tx_q[$], rx_q[$];

  // Starting channel set to a legal multiple of four
  xpc_host_ports #(.START_CHANNEL(7'h04)) xpc_host_ports_i (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .TX_LANE_CLK(TX_LANE_CLK),
    .TX_LANE_BUS(TX_LANE_BUS), .TX_LANE_VALID(TX_LANE_VALID),
    .TX_READY(TX_READY), .PCS_TX_DATA(PCS_TX_DATA),
    .PCS_TX_CTRL(PCS_TX_CTRL), .PCS_TX_VALID(PCS_TX_VALID),
    .PCS_RX_DATA(PCS_RX_DATA), .PCS_RX_CTRL(PCS_RX_CTRL),
    .PCS_RX_VALID(PCS_RX_VALID), .RX_LANE_BUS(RX_LANE_BUS),
    .RX_LANE_VALID(RX_LANE_VALID), .RX_LANE_READY(RX_LANE_READY),
    .RX_LANE_CLK(RX_LANE_CLK), .MGMT_RESET(MGMT_RESET),
    .PHY_RESET(PHY_RESET), .BLOCK_LOCK_IN(BLOCK_LOCK_IN),
    .HIGH_ERROR_RATE_IN(HIGH_ERROR_RATE_IN), .BLOCK_LOCK(BLOCK_LOCK),
    .HIGH_ERROR_RATE_FLAG(HIGH_ERROR_RATE_FLAG),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .BR_ADDR(BR_ADDR), .BR_WDATA(BR_WDATA),
    .BR_WRITE(BR_WRITE), .BR_READ(BR_READ), .BR_RDATA(BR_RDATA),
    .BR_WAIT(BR_WAIT));

  xpc_bridge_model xpc_bridge_model_i (
    .clk(CLK_SYS), .slow(slow), .br_addr(BR_ADDR), .br_wdata(BR_WDATA),
    .br_write(BR_WRITE), .br_read(BR_READ), .br_rdata(BR_RDATA),
    .br_wait(BR_WAIT));

  // Comparison core shared by the typed compare tasks
  task automatic tally(string n, logic [71:0] e, logic [71:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : tally
  task automatic cmp_lane(string n, logic [71:0] e, logic [71:0] g);
    tally(n, e, g);
  endtask : cmp_lane
  task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
    tally(n, 72'(e), 72'(g));
  endtask : cmp_word
  task automatic cmp_flag(string n, logic e, logic g);
    tally(n, 72'(e), 72'(g));
  endtask : cmp_flag

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic timeout();
    failures++;
    $display("wait limit reached");
    wrap_up();
  endtask : timeout

  // Lane layout: lane k holds data byte k and control bit k
  function automatic logic [71:0] lanes(logic [63:0] d, logic [7:0] c);
    logic [71:0] v;
    for (int k = 0; k < 8; k++)
      v[9*k +: 9] = {c[k], d[8*k +: 8]};
    return v;
  endfunction : lanes

  // Register write: address and data together, each released when taken
  task automatic axi_wr(logic [8:0] idx, logic [31:0] d, logic [3:0] s,
                        output logic [1:0] r);
    bit aw, w, b;
    b = 1'b0;
    @(posedge CLK_SYS);
    S_AXI_AWADDR  <= {idx, 2'h0};
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    for (int n = 0; n < 300 && !b; n++) begin
      @(negedge CLK_SYS);
      aw = S_AXI_AWVALID && S_AXI_AWREADY;
      w  = S_AXI_WVALID && S_AXI_WREADY;
      b  = S_AXI_BVALID && S_AXI_BREADY;
      r  = S_AXI_BRESP;
      @(posedge CLK_SYS);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
      if (b) S_AXI_BREADY <= 1'b0;
    end
    if (!b) timeout();
  endtask : axi_wr

  // Register read: address held until taken, data taken with rvalid
  task automatic axi_rd(logic [8:0] idx, output logic [31:0] d,
                        output logic [1:0] r);
    bit a, v;
    v = 1'b0;
    @(posedge CLK_SYS);
    S_AXI_ARADDR  <= {idx, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    for (int n = 0; n < 300 && !v; n++) begin
      @(negedge CLK_SYS);
      a = S_AXI_ARVALID && S_AXI_ARREADY;
      v = S_AXI_RVALID && S_AXI_RREADY;
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      @(posedge CLK_SYS);
      if (a) S_AXI_ARVALID <= 1'b0;
      if (v) S_AXI_RREADY <= 1'b0;
    end
    if (!v) timeout();
  endtask : axi_rd

  // MAC source: random words, valid offered whether or not ready is up
  task automatic tx_burst(int n);
    repeat (n) begin
      @(posedge CLK_SYS);
      TX_LANE_BUS   <= 72'({$urandom, $urandom, $urandom});
      TX_LANE_VALID <= ($urandom_range(3, 0) != 0);
    end
    @(posedge CLK_SYS);
    TX_LANE_VALID <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
  endtask : tx_burst

  // Count cycles of one phy reset pulse
  task automatic reset_span(output int hi);
    hi = 0;
    for (int n = 0; n < 200 && !(hi > 0 && !PHY_RESET); n++) begin
      @(negedge CLK_SYS);
      if (PHY_RESET) hi++;
      if (hi == 10) cmp_flag("tx ready in reset", 1'b0, TX_READY);
    end
  endtask : reset_span

  // Reference model of both streams, checked at every delivered word
  always @(negedge CLK_SYS) begin
    if (PCS_TX_VALID) begin
      if (tx_q.size() == 0) tally("tx word unasked", 72'h0, 72'h1);
      else cmp_lane("pcs tx", tx_q.pop_front(),
                    lanes(PCS_TX_DATA, PCS_TX_CTRL));
    end
    if (RESETN && TX_LANE_VALID && TX_READY) begin
      tx_q.push_back(TX_LANE_BUS);
      tx_taken++;
    end
    if (RX_LANE_VALID && RX_LANE_READY) begin
      if (rx_q.size() == 0) tally("rx word unasked", 72'h0, 72'h1);
      else cmp_lane("rx lanes", rx_q.pop_front(), RX_LANE_BUS);
    end
    if (RESETN && PCS_RX_VALID) begin
      if (!RX_LANE_VALID || RX_LANE_READY)
        rx_q.push_back(lanes(PCS_RX_DATA, PCS_RX_CTRL));
      else
        rx_drops++;
    end
  end

  // System clock at 250 MHz and MAC lane clock at 156.25 MHz
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    TX_LANE_CLK = 1'b0;
    forever #3.2 TX_LANE_CLK = ~TX_LANE_CLK;
  end

  // Main sequence
  initial begin
    logic [31:0] d, wd;
    logic [1:0]  r;
    logic [8:0]  idx;
    int          hi;
    void'($urandom(69384));
    {TX_LANE_BUS, TX_LANE_VALID, PCS_RX_DATA, PCS_RX_CTRL, PCS_RX_VALID,
     RX_LANE_READY, MGMT_RESET, BLOCK_LOCK_IN, HIGH_ERROR_RATE_IN, slow,
     S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_WVALID,
     S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    RESETN = 1'b0;
    repeat (5) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    for (int n = 0; n < 100 && TX_READY !== 1'b1; n++) @(negedge CLK_SYS);
    cmp_flag("tx ready", 1'b1, TX_READY);
    // Receive lane clock toggles every system cycle
    hi = RX_LANE_CLK;
    @(negedge CLK_SYS);
    cmp_flag("rx lane clock", !hi[0], RX_LANE_CLK);
    axi_rd(xpc_pkg::REG_CTRL, d, r);
    cmp_word("ctrl reset", xpc_pkg::CTRL_RST, d);
    // Stream with ready up, then ignored while ready is down
    tx_burst(40);
    axi_wr(xpc_pkg::REG_CTRL, 32'h0, 4'h0, r);
    axi_rd(xpc_pkg::REG_CTRL, d, r);
    cmp_word("ctrl no strobe", xpc_pkg::CTRL_RST, d);
    axi_wr(xpc_pkg::REG_CTRL, 32'h0, 4'hf, r);
    @(negedge CLK_SYS);
    cmp_flag("tx ready off", 1'b0, TX_READY);
    tx_burst(10);
    axi_wr(xpc_pkg::REG_CTRL, 32'h1, 4'hf, r);
    tx_burst(20);
    axi_rd(xpc_pkg::REG_TXCNT, d, r);
    cmp_word("tx count", 32'(tx_taken), d);
    // Receive stream with the MAC stalling at random
    repeat (60) begin
      @(posedge CLK_SYS);
      PCS_RX_DATA   <= {$urandom, $urandom};
      PCS_RX_CTRL   <= 8'($urandom);
      PCS_RX_VALID  <= 1'($urandom_range(1, 0));
      RX_LANE_READY <= ($urandom_range(2, 0) != 0);
    end
    @(posedge CLK_SYS);
    PCS_RX_VALID  <= 1'b0;
    RX_LANE_READY <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    cmp_flag("rx drained", 1'b1, rx_q.size() == 0);
    axi_rd(xpc_pkg::REG_RXDROP, d, r);
    cmp_word("rx drops", 32'(rx_drops), d);
    // Status pins and status register for every flag pair
    for (int c = 0; c < 4; c++) begin
      @(posedge CLK_SYS);
      BLOCK_LOCK_IN      <= c[0];
      HIGH_ERROR_RATE_IN <= c[1];
      repeat (5) @(posedge CLK_SYS);
      cmp_flag("block lock", c[0], BLOCK_LOCK);
      cmp_flag("high error", c[1], HIGH_ERROR_RATE_FLAG);
      axi_rd(xpc_pkg::REG_STAT, d, r);
      cmp_word("stat flags", 32'(c), {30'h0, d[1:0]});
    end
    // Forwarded round trips, prompt and stalling far side
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      idx = 9'($urandom_range(9'h1ef, 0));
      wd  = $urandom;
      axi_wr(idx, wd, 4'hf, r);
      cmp_word("fwd bresp", 32'(xpc_pkg::RESP_OKAY), 32'(r));
      axi_rd(idx, d, r);
      cmp_word("fwd data", wd, d);
      cmp_word("fwd rresp", 32'(xpc_pkg::RESP_OKAY), 32'(r));
    end
    axi_rd(9'h1f4, d, r);
    cmp_word("bad rresp", 32'(xpc_pkg::RESP_SLVERR), 32'(r));
    axi_wr(9'h1ff, 32'h5, 4'hf, r);
    cmp_word("bad bresp", 32'(xpc_pkg::RESP_SLVERR), 32'(r));
    // Management reset edge gives one timed phy reset
    @(posedge CLK_SYS);
    MGMT_RESET <= 1'b1;
    reset_span(hi);
    cmp_word("reset span", 32'(xpc_pkg::RST_HOLD_CYC), 32'(hi));
    cmp_flag("tx ready back", 1'b1, TX_READY);
    MGMT_RESET <= 1'b0;
    wrap_up();
  end
endmodule : xpc_host_ports_test
`default_nettype wire
